// ### logic/esr_pin_group.sv
`timescale 1ns/1ns
module esr_pin_group #(
  parameter int W = 6
) (
  // Selected sharing mode
  input  wire esr_pkg::esr_sp_mode_t mode,
  // Three candidate sources
  input  wire logic [W-1:0]          src0_out,
  input  wire logic [W-1:0]          src0_oe_n,
  input  wire logic [W-1:0]          src1_out,
  input  wire logic [W-1:0]          src1_oe_n,
  input  wire logic [W-1:0]          src2_out,
  input  wire logic [W-1:0]          src2_oe_n,
  // Pins
  input  wire logic [W-1:0]          pin_in,
  output logic [W-1:0]               pin_out,
  output logic [W-1:0]               pin_oe_n,
  // Pin levels handed back to the selected source
  output logic [W-1:0]               src0_in,
  output logic [W-1:0]               src1_in,
  output logic [W-1:0]               src2_in
);

  // A group needs at least one pin
  if (W < 1) begin : g_chk
    $error("esr_pin_group: W must be at least 1");
  end

  // Pure steering; unselected sources see zero
  always_comb begin
    pin_out  = '0;
    pin_oe_n = '1;
    src0_in  = '0;
    src1_in  = '0;
    src2_in  = '0;
    unique case (mode)
      esr_pkg::SP_CARD: begin
        pin_out  = src0_out;
        pin_oe_n = src0_oe_n;
        src0_in  = pin_in;
      end
      esr_pkg::SP_AUDIO_GP: begin
        pin_out  = src1_out;
        pin_oe_n = src1_oe_n;
        src1_in  = pin_in;
      end
      esr_pkg::SP_GPIO: begin
        pin_out  = src2_out;
        pin_oe_n = src2_oe_n;
        src2_in  = pin_in;
      end
      esr_pkg::SP_RSVD: begin
        // Reserved code releases the pins rather than guess
        pin_oe_n = '1;
      end
    endcase
  end

endmodule

// ### logic/esr_pin_routing.sv
`timescale 1ns/1ns
// Operation
// - New routing applies on next CPU clock
// - Register decoded at I/O port 0x1C00
// - Select bit 1 gives address pin GPIO
// - Six address select bits, R/W, reset 0
// - Bits 15, 7, 6 read zero, unwritable
// - Parallel mode field bits 14:12, reset 000
// - Mode 000: full LCD bridge on pins
// - Mode 001: SPI, GPIO, UART, audio one
// - Mode 010: LCD pixels and eight GPIO
// - Mode 011: LCD pixels, SPI, audio two
// - Mode 100: LCD pixels, audio one, UART
// - Mode 101: LCD pixels, SPI, UART
// - Mode 110: SPI, both audio, GPIO
// - Two serial port fields at 11:10, 9:8
// - Serial one: card, audio+GPIO, GPIO
// - Serial zero: card, audio+GPIO, GPIO
// - Address 15..20 map to GPIO 21..26
module esr_pin_routing (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // CPU I/O port
  input  wire esr_pkg::esr_io_req_t io_req,
  output logic [15:0]               io_rdata,
  output logic                      io_rvalid,
  // Display bridge
  input  wire esr_pkg::esr_pp_pad_t lcd_pad,
  output logic [20:0]               lcd_in,
  // SPI
  input  wire logic [6:0]           spi_out,
  input  wire logic [6:0]           spi_oe_n,
  output logic [6:0]                spi_in,
  // UART
  input  wire logic [3:0]           uart_out,
  input  wire logic [3:0]           uart_oe_n,
  output logic [3:0]                uart_in,
  // First audio serial port
  input  wire logic [3:0]           aud_first_out,
  input  wire logic [3:0]           aud_first_oe_n,
  output logic [3:0]                aud_first_in,
  // Second audio serial port
  input  wire logic [3:0]           aud_second_out,
  input  wire logic [3:0]           aud_second_oe_n,
  output logic [3:0]                aud_second_in,
  // Serial port 0 sources
  input  wire logic [5:0]           card0_out,
  input  wire logic [5:0]           card0_oe_n,
  output logic [5:0]                card0_in,
  input  wire logic [3:0]           aud0_out,
  input  wire logic [3:0]           aud0_oe_n,
  output logic [3:0]                aud0_in,
  // Serial port 1 sources
  input  wire logic [5:0]           card1_out,
  input  wire logic [5:0]           card1_oe_n,
  output logic [5:0]                card1_in,
  input  wire logic [3:0]           aud1_out,
  input  wire logic [3:0]           aud1_oe_n,
  output logic [3:0]                aud1_in,
  // External memory address bits 20:15
  input  wire logic [5:0]           emif_addr,
  // GPIO controller
  input  wire logic [31:0]          gpio_out,
  input  wire logic [31:0]          gpio_oe_n,
  output logic [31:0]               gpio_in,
  // Parallel port pins
  input  wire logic [20:0]          pp_pin_in,
  output logic [20:0]               pp_pin_out,
  output logic [20:0]               pp_pin_oe_n,
  // Serial port pins
  input  wire logic [5:0]           sp0_pin_in,
  output logic [5:0]                sp0_pin_out,
  output logic [5:0]                sp0_pin_oe_n,
  input  wire logic [5:0]           sp1_pin_in,
  output logic [5:0]                sp1_pin_out,
  output logic [5:0]                sp1_pin_oe_n,
  // Upper address pins
  input  wire logic [5:0]           addr_pin_in,
  output logic [5:0]                addr_pin_out,
  output logic [5:0]                addr_pin_oe_n
);

  esr_pkg::esr_cfg_t cfg;       // Current routing
  logic [7:0]        pgp_out;   // GPIO set for the parallel port
  logic [7:0]        pgp_oe_n;  // Its enables
  logic [7:0]        pgp_in;    // Levels handed back to it
  logic [5:0]        s0_src1_in; // Serial 0 audio mode returns
  logic [5:0]        s0_src2_in; // Serial 0 GPIO mode returns
  logic [5:0]        s1_src1_in; // Serial 1 audio mode returns
  logic [5:0]        s1_src2_in; // Serial 1 GPIO mode returns

  // Parallel-port GPIO order: 31..27 then 20..18
  function automatic logic [7:0] pp_gp(input logic [31:0] v);
    pp_gp = {v[31:27], v[20:18]};
  endfunction

  // Register and its I/O port decode
  esr_route_reg u_reg (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .io_req    (io_req),
    .io_rdata  (io_rdata),
    .io_rvalid (io_rvalid),
    .cfg       (cfg)
  );

  // GPIO subset offered to the parallel port
  assign pgp_out  = pp_gp(gpio_out);
  assign pgp_oe_n = pp_gp(gpio_oe_n);

  // Parallel port pin drive per mode; spare pins released
  always_comb begin
    pp_pin_out  = '0;
    pp_pin_oe_n = '1;
    unique case (cfg.pp)
      esr_pkg::PP_LCD16: begin
        pp_pin_out  = lcd_pad.out;
        pp_pin_oe_n = lcd_pad.oe_n;
      end
      esr_pkg::PP_SPI_GP_UART_AUD1: begin
        // SPI 6:0, GPIO 12:7, UART 16:13, audio 20:17
        pp_pin_out  = {aud_first_out, uart_out, pgp_out[5:0],
                       spi_out};
        pp_pin_oe_n = {aud_first_oe_n, uart_oe_n, pgp_oe_n[5:0],
                       spi_oe_n};
      end
      esr_pkg::PP_LCD8_GP: begin
        pp_pin_out[15:0]  = {pgp_out, lcd_pad.out[7:0]};
        pp_pin_oe_n[15:0] = {pgp_oe_n, lcd_pad.oe_n[7:0]};
      end
      esr_pkg::PP_LCD8_SPI_AUD2: begin
        pp_pin_out[15:0]  = {aud_second_out, spi_out[3:0],
                             lcd_pad.out[7:0]};
        pp_pin_oe_n[15:0] = {aud_second_oe_n, spi_oe_n[3:0],
                             lcd_pad.oe_n[7:0]};
      end
      esr_pkg::PP_LCD8_AUD1_UART: begin
        pp_pin_out[15:0]  = {uart_out, aud_first_out,
                             lcd_pad.out[7:0]};
        pp_pin_oe_n[15:0] = {uart_oe_n, aud_first_oe_n,
                             lcd_pad.oe_n[7:0]};
      end
      esr_pkg::PP_LCD8_SPI_UART: begin
        pp_pin_out[15:0]  = {uart_out, spi_out[3:0],
                             lcd_pad.out[7:0]};
        pp_pin_oe_n[15:0] = {uart_oe_n, spi_oe_n[3:0],
                             lcd_pad.oe_n[7:0]};
      end
      esr_pkg::PP_SPI_AUD1_AUD2_GP: begin
        // SPI 6:0, audio one 10:7, audio two 14:11, GPIO 20:15
        pp_pin_out  = {pgp_out[5:0], aud_second_out, aud_first_out,
                       spi_out};
        pp_pin_oe_n = {pgp_oe_n[5:0], aud_second_oe_n,
                       aud_first_oe_n, spi_oe_n};
      end
      esr_pkg::PP_RSVD: begin
        // Undefined routing: nothing drives the pins
        pp_pin_oe_n = '1;
      end
    endcase
  end

  // Parallel port pin levels back to whichever source owns them
  always_comb begin
    lcd_in        = '0;
    spi_in        = '0;
    uart_in       = '0;
    aud_first_in  = '0;
    aud_second_in = '0;
    pgp_in        = '0;
    unique case (cfg.pp)
      esr_pkg::PP_LCD16: begin
        lcd_in = pp_pin_in;
      end
      esr_pkg::PP_SPI_GP_UART_AUD1: begin
        spi_in       = pp_pin_in[6:0];
        pgp_in[5:0]  = pp_pin_in[12:7];
        uart_in      = pp_pin_in[16:13];
        aud_first_in = pp_pin_in[20:17];
      end
      esr_pkg::PP_LCD8_GP: begin
        lcd_in[7:0] = pp_pin_in[7:0];
        pgp_in      = pp_pin_in[15:8];
      end
      esr_pkg::PP_LCD8_SPI_AUD2: begin
        lcd_in[7:0]   = pp_pin_in[7:0];
        spi_in[3:0]   = pp_pin_in[11:8];
        aud_second_in = pp_pin_in[15:12];
      end
      esr_pkg::PP_LCD8_AUD1_UART: begin
        lcd_in[7:0]  = pp_pin_in[7:0];
        aud_first_in = pp_pin_in[11:8];
        uart_in      = pp_pin_in[15:12];
      end
      esr_pkg::PP_LCD8_SPI_UART: begin
        lcd_in[7:0] = pp_pin_in[7:0];
        spi_in[3:0] = pp_pin_in[11:8];
        uart_in     = pp_pin_in[15:12];
      end
      esr_pkg::PP_SPI_AUD1_AUD2_GP: begin
        spi_in        = pp_pin_in[6:0];
        aud_first_in  = pp_pin_in[10:7];
        aud_second_in = pp_pin_in[14:11];
        pgp_in[5:0]   = pp_pin_in[20:15];
      end
      esr_pkg::PP_RSVD: begin
        // Sources see idle zero while reserved
        lcd_in = '0;
      end
    endcase
  end

  // Serial port 1: card, audio plus GPIO 11:10, GPIO 11:6
  esr_pin_group #(.W(esr_pkg::SP_PINS)) u_sp1 (
    .mode      (cfg.sp1),
    .src0_out  (card1_out),
    .src0_oe_n (card1_oe_n),
    .src1_out  ({gpio_out[11:10], aud1_out}),
    .src1_oe_n ({gpio_oe_n[11:10], aud1_oe_n}),
    .src2_out  (gpio_out[esr_pkg::SP1_GP_BASE +: 6]),
    .src2_oe_n (gpio_oe_n[esr_pkg::SP1_GP_BASE +: 6]),
    .pin_in    (sp1_pin_in),
    .pin_out   (sp1_pin_out),
    .pin_oe_n  (sp1_pin_oe_n),
    .src0_in   (card1_in),
    .src1_in   (s1_src1_in),
    .src2_in   (s1_src2_in)
  );

  // Serial port 0: card, audio plus GPIO 5:4, GPIO 5:0
  esr_pin_group #(.W(esr_pkg::SP_PINS)) u_sp0 (
    .mode      (cfg.sp0),
    .src0_out  (card0_out),
    .src0_oe_n (card0_oe_n),
    .src1_out  ({gpio_out[5:4], aud0_out}),
    .src1_oe_n ({gpio_oe_n[5:4], aud0_oe_n}),
    .src2_out  (gpio_out[esr_pkg::SP0_GP_BASE +: 6]),
    .src2_oe_n (gpio_oe_n[esr_pkg::SP0_GP_BASE +: 6]),
    .pin_in    (sp0_pin_in),
    .pin_out   (sp0_pin_out),
    .pin_oe_n  (sp0_pin_oe_n),
    .src0_in   (card0_in),
    .src1_in   (s0_src1_in),
    .src2_in   (s0_src2_in)
  );

  // Audio inputs are the low four pins of the mixed mode
  assign aud1_in = s1_src1_in[3:0];
  assign aud0_in = s0_src1_in[3:0];

  // Upper address pins: EMIF drives unless selected, GPIO when selected
  always_comb begin
    for (int i = 0; i < esr_pkg::ADDR_PINS; i++) begin
      if (cfg.addr_gp[i]) begin
        // Address 15+i becomes GPIO 21+i
        addr_pin_out[i]  = gpio_out[esr_pkg::ADDR_GP_BASE + i];
        addr_pin_oe_n[i] = gpio_oe_n[esr_pkg::ADDR_GP_BASE + i];
      end else begin
        // Address output keeps its pin
        addr_pin_out[i]  = emif_addr[i];
        addr_pin_oe_n[i] = 1'b0;
      end
    end
  end

  // GPIO input gather; groups are disjoint so OR merges them
  always_comb begin
    gpio_in        = '0;
    gpio_in[5:0]   = s0_src2_in;
    gpio_in[5:4]   = gpio_in[5:4] | s0_src1_in[5:4];
    gpio_in[11:6]  = s1_src2_in;
    gpio_in[11:10] = gpio_in[11:10] | s1_src1_in[5:4];
    gpio_in[20:18] = pgp_in[2:0];
    gpio_in[31:27] = pgp_in[7:3];
    // Address pin levels only reach GPIO while selected
    gpio_in[esr_pkg::ADDR_GP_BASE +: 6] =
      addr_pin_in & cfg.addr_gp;
  end

  // Software owns clock gating and peripheral reset around a change;
  // the mux switches at once and does not glitch-protect pins.

endmodule

// ### logic/esr_pkg.sv
package esr_pkg;

  // I/O port address of the routing register
  localparam logic [15:0] ROUTE_ADDR    = 16'h1c00;

  // Field positions inside the routing register
  localparam int          PP_LSB        = 12;
  localparam int          SP1_LSB       = 10;
  localparam int          SP0_LSB       = 8;
  localparam int          ADDR_LSB      = 0;

  // Writable bits; 15, 7 and 6 stay zero
  localparam logic [15:0] ROUTE_WMASK   = 16'h7f3f;
  localparam logic [15:0] ROUTE_RESET   = 16'h0000;

  // Pin group widths
  localparam int          PP_PINS       = 21;
  localparam int          SP_PINS       = 6;
  localparam int          ADDR_PINS     = 6;
  localparam int          GPIO_W        = 32;

  // First GPIO taken over by the upper address pins
  localparam int          ADDR_GP_BASE  = 21;
  // GPIO used on serial port 0 and serial port 1
  localparam int          SP0_GP_BASE   = 0;
  localparam int          SP1_GP_BASE   = 6;

  // Parallel port sharing modes
  typedef enum logic [2:0] {
    PP_LCD16,
    PP_SPI_GP_UART_AUD1,
    PP_LCD8_GP,
    PP_LCD8_SPI_AUD2,
    PP_LCD8_AUD1_UART,
    PP_LCD8_SPI_UART,
    PP_SPI_AUD1_AUD2_GP,
    PP_RSVD
  } esr_pp_mode_t;

  // Serial port sharing modes
  typedef enum logic [1:0] {
    SP_CARD,
    SP_AUDIO_GP,
    SP_GPIO,
    SP_RSVD
  } esr_sp_mode_t;

  // I/O port request from the CPU
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } esr_io_req_t;

  // Decoded routing configuration
  typedef struct packed {
    esr_pp_mode_t pp;
    esr_sp_mode_t sp1;
    esr_sp_mode_t sp0;
    logic [5:0]   addr_gp;
  } esr_cfg_t;

  // Drive of a full parallel port wide source
  typedef struct packed {
    logic [20:0] out;
    logic [20:0] oe_n;
  } esr_pp_pad_t;

endpackage

// ### logic/esr_route_reg.sv
`timescale 1ns/1ns
module esr_route_reg (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // CPU I/O port
  input  wire esr_pkg::esr_io_req_t io_req,
  output logic [15:0]             io_rdata,
  output logic                    io_rvalid,
  // Routing configuration
  output esr_pkg::esr_cfg_t       cfg
);

  logic [15:0] route_q;   // Stored register value
  logic        hit;       // Address match

  // Decode of the single port address
  assign hit = (io_req.addr == esr_pkg::ROUTE_ADDR);

  // Register store; reserved bits never take a write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      route_q <= esr_pkg::ROUTE_RESET;
    end else if (io_req.wr && hit) begin
      route_q <= io_req.wdata & esr_pkg::ROUTE_WMASK;
    end
  end

  // Read data held in a flop, valid one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_rdata  <= 16'h0000;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_req.rd && hit;
      if (io_req.rd && hit) begin
        io_rdata <= route_q;
      end
    end
  end

  // Field split; routing follows from the cycle after the write
  assign cfg.pp      = esr_pkg::esr_pp_mode_t'(
                         route_q[esr_pkg::PP_LSB +: 3]);
  assign cfg.sp1     = esr_pkg::esr_sp_mode_t'(
                         route_q[esr_pkg::SP1_LSB +: 2]);
  assign cfg.sp0     = esr_pkg::esr_sp_mode_t'(
                         route_q[esr_pkg::SP0_LSB +: 2]);
  assign cfg.addr_gp = route_q[esr_pkg::ADDR_LSB +: 6];

endmodule

// ### verif/esr_pad_model.sv
`timescale 1ns/1ns
module esr_pad_model #(
  parameter int W = 6
) (
  // Clock
  input  wire logic         clk_sys,
  // Pin drive from the device
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  // Level seen back on the pins
  output logic [W-1:0]      pin_in
);
  // Undriven pins toggle, so a stale level can never pass as a match
  logic [W-1:0] float_q = '0;

  // Pattern that changes every cycle
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  // Driven pins echo the device, released ones float
  assign pin_in = (pin_out & ~pin_oe_n) | (float_q & pin_oe_n);
endmodule

// ### verif/esr_routing_props.sv
`timescale 1ns/1ns
module esr_routing_props (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst,
  // CPU I/O port
  input wire esr_pkg::esr_io_req_t io_req,
  input wire logic [15:0]          io_rdata,
  input wire logic                 io_rvalid,
  // Parallel port
  input wire esr_pkg::esr_pp_pad_t lcd_pad,
  input wire logic [6:0]           spi_out,
  input wire logic [3:0]           aud_first_out,
  input wire logic [20:0]          pp_pin_out,
  input wire logic [20:0]          pp_pin_oe_n,
  // Serial ports
  input wire logic [5:0]           card1_out,
  input wire logic [5:0]           sp1_pin_out,
  input wire logic [5:0]           sp0_pin_out,
  // Address pins and GPIO
  input wire logic [5:0]           emif_addr,
  input wire logic [31:0]          gpio_out,
  input wire logic [31:0]          gpio_in,
  input wire logic [5:0]           addr_pin_in,
  input wire logic [5:0]           addr_pin_out,
  input wire logic [5:0]           addr_pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Shadow of the register, rebuilt from accepted writes only
  logic [15:0] shadow_q;

  // Shadow update; dropped bits never land here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shadow_q <= esr_pkg::ROUTE_RESET;
    end else if (io_req.wr && io_req.addr == esr_pkg::ROUTE_ADDR) begin
      shadow_q <= io_req.wdata & esr_pkg::ROUTE_WMASK;
    end
  end

  // Request steps
  sequence rd_hit_s;
    io_req.rd && io_req.addr == esr_pkg::ROUTE_ADDR;
  endsequence
  sequence wr_lcd_s;
    io_req.wr && io_req.addr == esr_pkg::ROUTE_ADDR &&
      io_req.wdata[14:12] == 3'h0;
  endsequence

  read_answer_a: assert property (rd_hit_s |=> io_rvalid)
    else $error("read hit got no answer");
  no_stray_a: assert property (io_rvalid |->
    $past(io_req.rd && io_req.addr == esr_pkg::ROUTE_ADDR))
    else $error("answer without read hit");
  read_value_a: assert property (
    rd_hit_s |=> io_rdata == $past(shadow_q))
    else $error("read data differs from written value");
  reserved_zero_a: assert property (
    io_rvalid |-> !io_rdata[15] && io_rdata[7:6] == 2'h0)
    else $error("reserved bit read as one");
  lcd_next_a: assert property (wr_lcd_s |=>
    pp_pin_out == lcd_pad.out && pp_pin_oe_n == lcd_pad.oe_n)
    else $error("display bridge not on pins next cycle");
  mode_one_a: assert property (shadow_q[14:12] == 3'h1 |->
    pp_pin_out[6:0] == spi_out && pp_pin_out[20:17] == aud_first_out)
    else $error("mode one layout wrong");
  pixel_gpio_a: assert property (
    shadow_q[14:12] == 3'h2 |-> pp_pin_oe_n[20:16] == 5'h1f)
    else $error("unused pins driven in mode two");
  card_one_a: assert property (
    shadow_q[11:10] == 2'h0 |-> sp1_pin_out == card1_out)
    else $error("serial port one not on card");
  gpio_zero_a: assert property (
    shadow_q[9:8] == 2'h2 |-> sp0_pin_out == gpio_out[5:0])
    else $error("serial port zero not on gpio");
  addr_emif_a: assert property (!shadow_q[0] |->
    addr_pin_out[0] == emif_addr[0] && !addr_pin_oe_n[0])
    else $error("address pin lost memory function");
  addr_gpio_a: assert property (shadow_q[5] |->
    addr_pin_out[5] == gpio_out[26] && gpio_in[26] == addr_pin_in[5])
    else $error("top address pin not on gpio");
endmodule

bind esr_pin_routing esr_routing_props esr_routing_props_i (
  .clk_sys, .rst, .io_req, .io_rdata, .io_rvalid, .lcd_pad, .spi_out,
  .aud_first_out, .pp_pin_out, .pp_pin_oe_n, .card1_out, .sp1_pin_out,
  .sp0_pin_out, .emif_addr, .gpio_out, .gpio_in, .addr_pin_in,
  .addr_pin_out, .addr_pin_oe_n);

// ### verif/tb_esr_pin_routing.sv
`timescale 1ns/1ns
module tb_esr_pin_routing;
  // Clock, reset and CPU port
  logic                 clk_sys, rst;
  esr_pkg::esr_io_req_t io_req;
  logic [15:0]          io_rdata, reg_m;
  logic                 io_rvalid;
  // Peripheral sources, all fed from one random vector
  logic [191:0]         src_r;
  esr_pkg::esr_pp_pad_t lcd_pad;
  logic [20:0]          lcd_in, pp_pin_in, pp_pin_out, pp_pin_oe_n;
  logic [6:0]           spi_out, spi_oe_n, spi_in;
  logic [3:0]           uart_out, uart_oe_n, uart_in;
  logic [3:0]           aud_first_out, aud_first_oe_n, aud_first_in;
  logic [3:0]           aud_second_out, aud_second_oe_n, aud_second_in;
  logic [3:0]           aud0_out, aud0_oe_n, aud0_in;
  logic [3:0]           aud1_out, aud1_oe_n, aud1_in;
  logic [5:0]           card0_out, card0_oe_n, card0_in;
  logic [5:0]           card1_out, card1_oe_n, card1_in;
  logic [5:0]           emif_addr, sp0_pin_in, sp0_pin_out, sp0_pin_oe_n;
  logic [5:0]           sp1_pin_in, sp1_pin_out, sp1_pin_oe_n;
  logic [5:0]           addr_pin_in, addr_pin_out, addr_pin_oe_n;
  logic [31:0]          gpio_out, gpio_oe_n, gpio_in;
  // Scoreboard
  logic [15:0]          exp_q[$];
  int                   err_count, n_tests;

  assign {lcd_pad, spi_out, spi_oe_n, uart_out, uart_oe_n, aud_first_out,
          aud_first_oe_n, aud_second_out, aud_second_oe_n, card0_out,
          card0_oe_n, aud0_out, aud0_oe_n, card1_out, card1_oe_n,
          aud1_out, aud1_oe_n, emif_addr, gpio_out, gpio_oe_n}
          = src_r[189:0];

  esr_pin_routing esr_pin_routing_i (
    .clk_sys, .rst, .io_req, .io_rdata, .io_rvalid, .lcd_pad, .lcd_in,
    .spi_out, .spi_oe_n, .spi_in, .uart_out, .uart_oe_n, .uart_in,
    .aud_first_out, .aud_first_oe_n, .aud_first_in, .aud_second_out,
    .aud_second_oe_n, .aud_second_in, .card0_out, .card0_oe_n, .card0_in,
    .aud0_out, .aud0_oe_n, .aud0_in, .card1_out, .card1_oe_n, .card1_in,
    .aud1_out, .aud1_oe_n, .aud1_in, .emif_addr, .gpio_out, .gpio_oe_n,
    .gpio_in, .pp_pin_in, .pp_pin_out, .pp_pin_oe_n, .sp0_pin_in,
    .sp0_pin_out, .sp0_pin_oe_n, .sp1_pin_in, .sp1_pin_out, .sp1_pin_oe_n,
    .addr_pin_in, .addr_pin_out, .addr_pin_oe_n);

  // Board side of each pin group
  esr_pad_model #(.W(21)) pp_pad_i (.clk_sys, .pin_out(pp_pin_out),
    .pin_oe_n(pp_pin_oe_n), .pin_in(pp_pin_in));
  esr_pad_model #(.W(6)) sp0_pad_i (.clk_sys, .pin_out(sp0_pin_out),
    .pin_oe_n(sp0_pin_oe_n), .pin_in(sp0_pin_in));
  esr_pad_model #(.W(6)) sp1_pad_i (.clk_sys, .pin_out(sp1_pin_out),
    .pin_oe_n(sp1_pin_oe_n), .pin_in(sp1_pin_in));
  esr_pad_model #(.W(6)) addr_pad_i (.clk_sys, .pin_out(addr_pin_out),
    .pin_oe_n(addr_pin_oe_n), .pin_in(addr_pin_in));

  // Verdict and stop
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One comparison
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected parallel pins; o picks enables instead of data
  function automatic logic [20:0] pp_exp(input logic [2:0] m,
                                         input logic o);
    logic [20:0] l;
    logic [6:0]  s;
    logic [3:0]  u, a1, a2;
    logic [7:0]  g;
    l  = o ? lcd_pad.oe_n : lcd_pad.out;
    s  = o ? spi_oe_n : spi_out;
    u  = o ? uart_oe_n : uart_out;
    a1 = o ? aud_first_oe_n : aud_first_out;
    a2 = o ? aud_second_oe_n : aud_second_out;
    g  = o ? {gpio_oe_n[31:27], gpio_oe_n[20:18]}
           : {gpio_out[31:27], gpio_out[20:18]};
    // Unused pins released
    pp_exp = {21{o}};
    case (m)
      3'h0: pp_exp = l;
      3'h1: pp_exp = {a1, u, g[5:0], s};
      3'h2: pp_exp[15:0] = {g, l[7:0]};
      3'h3: pp_exp[15:0] = {a2, s[3:0], l[7:0]};
      3'h4: pp_exp[15:0] = {u, a1, l[7:0]};
      3'h5: pp_exp[15:0] = {u, s[3:0], l[7:0]};
      3'h6: pp_exp = {g[5:0], a2, a1, s};
      default: ;
    endcase
  endfunction

  // Expected serial pins
  function automatic logic [5:0] sp_exp(input logic [1:0] m,
    input logic [5:0] card, input logic [3:0] aud, input logic [5:0] gp);
    case (m)
      2'h0: sp_exp = card;
      2'h1: sp_exp = {gp[5:4], aud};
      2'h2: sp_exp = gp;
      default: sp_exp = 6'h00;
    endcase
  endfunction

  // New random peripheral drive; clocks count as gated meanwhile
  task automatic rnd();
    @(posedge clk_sys);
    src_r <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
  endtask

  // One port cycle; a read hit notes the value it must return
  task automatic xfer(input logic w, input logic r, input logic [15:0] a,
                      input logic [15:0] d);
    @(posedge clk_sys);
    io_req <= '{wr: w, rd: r, addr: a, wdata: d};
    if (r && a == esr_pkg::ROUTE_ADDR) exp_q.push_back(reg_m);
    if (w && a == esr_pkg::ROUTE_ADDR) reg_m = d & esr_pkg::ROUTE_WMASK;
    @(posedge clk_sys);
    io_req <= '0;
  endtask

  // Pin layout in the cycle after the last write
  task automatic check_pins();
    logic [2:0] m;
    logic [1:0] s1, s0;
    #1;
    m  = reg_m[14:12];
    s1 = reg_m[11:10];
    s0 = reg_m[9:8];
    chk("pp out", pp_exp(m, 1'b0), pp_pin_out);
    chk("pp oe", pp_exp(m, 1'b1), pp_pin_oe_n);
    chk("lcd in", (m == 3'h0) ? pp_pin_in : (m inside {[3'h2:3'h5]}) ?
        {13'h0, pp_pin_in[7:0]} : 21'h0, lcd_in);
    chk("spi in", (m == 3'h1 || m == 3'h6) ? pp_pin_in[6:0] :
        (m == 3'h3 || m == 3'h5) ? {3'h0, pp_pin_in[11:8]} : 7'h0,
        spi_in);
    chk("sp1", sp_exp(s1, card1_out, aud1_out,
        gpio_out[11:6]), sp1_pin_out);
    chk("sp1 oe", (&s1) ? 6'h3f : sp_exp(s1, card1_oe_n, aud1_oe_n,
        gpio_oe_n[11:6]), sp1_pin_oe_n);
    chk("card1 in", s1 == 2'h0 ? sp1_pin_in : 6'h0, card1_in);
    chk("sp0", sp_exp(s0, card0_out, aud0_out,
        gpio_out[5:0]), sp0_pin_out);
    chk("sp0 oe", (&s0) ? 6'h3f : sp_exp(s0, card0_oe_n, aud0_oe_n,
        gpio_oe_n[5:0]), sp0_pin_oe_n);
    chk("aud0", s0 == 2'h1 ? sp0_pin_in[3:0] : 4'h0, aud0_in);
    for (int i = 0; i < 6; i++) begin
      chk("addr pin", reg_m[i] ? gpio_out[21+i] : emif_addr[i],
          addr_pin_out[i]);
      chk("addr oe", reg_m[i] & gpio_oe_n[21+i],
          addr_pin_oe_n[i]);
      chk("addr gp", reg_m[i] & addr_pin_in[i],
          gpio_in[21+i]);
    end
  endtask

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Read answers against the oldest note
  always @(posedge clk_sys) begin
    if (io_rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("stray answer", 32'h0000_0000, 32'h0000_0001);
      else
        chk("read data", exp_q.pop_front(), io_rdata);
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [15:0] v;
    io_req = '0;
    src_r  = '0;
    rst    = 1'b1;
    reg_m  = esr_pkg::ROUTE_RESET;
    void'($urandom(32'hf44c));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    check_pins();
    xfer(1'b0, 1'b1, esr_pkg::ROUTE_ADDR, 16'h0000);
    // Every legal mode in turn; reserved codes come later
    for (int k = 0; k < 21; k++) begin
      v = 16'($urandom);
      v[14:12] = 3'(k % 7);
      v[11:10] = 2'($urandom % 3);
      v[9:8] = 2'($urandom % 3);
      rnd();
      xfer(1'b1, 1'b0, esr_pkg::ROUTE_ADDR, v);
      check_pins();
      xfer(1'b0, 1'b1, esr_pkg::ROUTE_ADDR, 16'h0000);
    end
    // Collision returns old value and parks reserved codes;
    // other addresses ignored
    xfer(1'b1, 1'b1, esr_pkg::ROUTE_ADDR, 16'hff00);
    check_pins();
    xfer(1'b1, 1'b1, 16'h1c01, 16'h0000);
    xfer(1'b0, 1'b1, esr_pkg::ROUTE_ADDR, 16'h0000);
    // Reset in mid-run
    repeat (3) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    reg_m = esr_pkg::ROUTE_RESET;
    check_pins();
    xfer(1'b0, 1'b1, esr_pkg::ROUTE_ADDR, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk("pending reads", 32'h0000_0000, exp_q.size());
    end_sim();
  end
endmodule
